// file: cpu_status_sfr_map_ctl.v
// Purpose: Status word, register-bank select, parity, register-map switch,
//          reset synchroniser and USB clock control bits
// Assumes: CPU core drives the special register port and the flag inputs
//          synchronous to ref_clk_in
// Notes:   Read data appears one cycle after the read strobe
`include "cpu_status_sfr_map_ctl_consts.vh"
`default_nettype none

module cpu_status_sfr_map_ctl #(
  parameter integer CODE_AW = 16,
  parameter integer XDATA_AW = 16
) (
  // Clock and resets
  input  wire                ref_clk_in,
  input  wire                nrst_in,
  input  wire                rst_pin_in,
  // Special register port
  input  wire [7:0]          sfr_addr_in,
  input  wire                sfr_wr_in,
  input  wire                sfr_rd_in,
  input  wire [7:0]          sfr_wdata_in,
  input  wire                sfr_bit_wr_in,
  input  wire [2:0]          sfr_bit_sel_in,
  input  wire                sfr_bit_val_in,
  output reg  [7:0]          sfr_rdata_out,
  output reg                 sfr_hit_out,
  output reg                 ext_std_sel_out,
  output reg                 pwr_second_sel_out,
  output reg                 bit_access_ok_out,
  // Flag updates from the datapath
  input  wire                instr_done_in,
  input  wire [7:0]          acc_in,
  input  wire                carry_we_in,
  input  wire                carry_in,
  input  wire                aux_carry_we_in,
  input  wire                aux_carry_in,
  input  wire                overflow_we_in,
  input  wire                overflow_in,
  // Memory address routing
  input  wire [2:0]          reg_num_in,
  input  wire [7:0]          dir_addr_in,
  input  wire                dir_indirect_in,
  input  wire [CODE_AW-1:0]  code_addr_in,
  input  wire [XDATA_AW-1:0] xdata_addr_in,
  output reg  [7:0]          reg_addr_out,
  output reg                 dir_sfr_sel_out,
  output reg                 dir_ram_sel_out,
  output reg  [CODE_AW-1:0]  code_addr_out,
  output reg  [XDATA_AW-1:0] xdata_addr_out,
  // Status outputs
  output reg                 carry_flag_out,
  output reg                 aux_carry_flag_out,
  output reg                 overflow_flag_out,
  output reg                 parity_flag_out,
  output reg  [1:0]          bank_sel_out,
  output reg                 da_low_fix_out,
  output reg                 map_select_out,
  output reg                 addr_latch_out_en_out,
  output reg                 sys_rst_out,
  // USB clock steering
  input  wire                pll_lock_in,
  output wire                usb_ls_clk_out,
  output wire                pll_run_out,
  output wire                usb_fs_sel_out,
  output wire                usb_ls_sel_out
);

  // Register state
  reg [7:0] status_word_reg;
  reg [7:0] status_word_next;
  reg       ale_en_reg;
  reg       ale_en_next;
  reg       map_sel_reg;
  reg       map_sel_next;
  reg [2:0] usb_ctl_reg;
  reg [2:0] usb_ctl_next;
  reg       rst_meta_reg;
  reg       rst_sync_reg;

  // Decode
  wire mapped_hit;
  wire hit_sw;
  wire hit_sc;
  wire hit_udc;
  wire local_hit;
  wire bit_ok;
  wire wr_sw;
  wire wr_sc;
  wire wr_udc;
  wire [7:0] bit_mask;
  wire [7:0] sc_view;
  wire [7:0] udc_view;
  wire [7:0] sc_merged;
  reg  [7:0] rd_mux;

  // Reset image of system control, used bit by bit
  localparam [7:0] SC_RST = `RST_SYS_CONTROL;

  // Two-flop synchroniser; async reset holds internal reset asserted
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= 1'b1;
    end else begin
      rst_meta_reg <= rst_pin_in;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  // A pulse shorter than one cycle may be missed; the source is
  // expected to hold the pin long enough

  // Only the second power register lives in the mapped area; all other
  // addresses answer in the standard area whatever the map bit says
  assign mapped_hit = map_sel_reg &&
                      (sfr_addr_in == `ADDR_POWER_CTL_SECOND);
  assign hit_sw  = !mapped_hit && (sfr_addr_in == `ADDR_STATUS_WORD);
  assign hit_sc  = !mapped_hit &&
                   (sfr_addr_in == `ADDR_SYSTEM_CONTROL);
  assign hit_udc = !mapped_hit &&
                   (sfr_addr_in == `ADDR_USB_DEV_CONTROL);
  assign local_hit = hit_sw | hit_sc | hit_udc;

  // Single-bit access only where the low three address bits are zero
  assign bit_ok   = (sfr_addr_in[2:0] == 3'b000);
  assign bit_mask = 8'h01 << sfr_bit_sel_in;

  assign wr_sw  = hit_sw  & (sfr_wr_in | (sfr_bit_wr_in & bit_ok));
  assign wr_sc  = hit_sc  & (sfr_wr_in | (sfr_bit_wr_in & bit_ok));
  assign wr_udc = hit_udc & (sfr_wr_in | (sfr_bit_wr_in & bit_ok));

  assign sc_view  = {2'b00, ale_en_reg, map_sel_reg, 4'h0};
  assign udc_view = {5'h00, usb_ctl_reg};

  // Merge a byte or single-bit write into the current value
  function [7:0] merge;
    input [7:0] cur;
    input [7:0] wdata;
    input       bitwr;
    input [7:0] mask;
    input       bval;
    begin
      if (bitwr) begin
        merge = bval ? (cur | mask) : (cur & ~mask);
      end else begin
        merge = wdata;
      end
    end
  endfunction

  // Merged view of a system control write, sliced below
  assign sc_merged = merge(sc_view, sfr_wdata_in, sfr_bit_wr_in & !sfr_wr_in,
                           bit_mask, sfr_bit_val_in);

  // Status word next value: software write, then hardware flag updates
  always @* begin
    status_word_next = status_word_reg;
    if (wr_sw) begin
      status_word_next = merge(status_word_reg, sfr_wdata_in,
                               sfr_bit_wr_in & !sfr_wr_in, bit_mask,
                               sfr_bit_val_in);
    end
    if (carry_we_in) begin
      status_word_next[`SW_CARRY] = carry_in;
    end
    if (aux_carry_we_in) begin
      status_word_next[`SW_AUX] = aux_carry_in;
    end
    if (overflow_we_in) begin
      status_word_next[`SW_OVFL] = overflow_in;
    end
    // Parity is owned by hardware; a software write to it is lost at
    // the next instruction end, as on the original core
    if (instr_done_in) begin
      status_word_next[`SW_PARITY] = ^acc_in;
    end
  end

  // System control and USB control next values
  always @* begin
    ale_en_next  = ale_en_reg;
    map_sel_next = map_sel_reg;
    usb_ctl_next = usb_ctl_reg;
    if (wr_sc) begin
      {ale_en_next, map_sel_next} =
        sc_merged[`SC_ALE_EN:`SC_MAP_SEL];
    end
    if (wr_udc) begin
      usb_ctl_next = sfr_wdata_in[2:0];
    end
  end

  // Register bank of control state
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_word_reg <= `RST_STATUS_WORD;
      ale_en_reg      <= 1'b1;
      map_sel_reg     <= 1'b0;
      usb_ctl_reg     <= 3'b000;
    end else if (rst_sync_reg) begin
      status_word_reg <= `RST_STATUS_WORD;
      ale_en_reg      <= SC_RST[`SC_ALE_EN];
      map_sel_reg     <= 1'b0;
      usb_ctl_reg     <= 3'b000;
    end else begin
      status_word_reg <= status_word_next;
      ale_en_reg      <= ale_en_next;
      map_sel_reg     <= map_sel_next;
      usb_ctl_reg     <= usb_ctl_next;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    case (1'b1)
      hit_sw:  rd_mux = status_word_reg;
      hit_sc:  rd_mux = sc_view;
      hit_udc: rd_mux = udc_view;
      default: rd_mux = 8'h00;
    endcase
  end

  // Registered port answers and external selects
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out      <= 8'h00;
      sfr_hit_out        <= 1'b0;
      ext_std_sel_out    <= 1'b0;
      pwr_second_sel_out <= 1'b0;
      bit_access_ok_out  <= 1'b0;
    end else begin
      sfr_rdata_out      <= sfr_rd_in ? rd_mux : 8'h00;
      sfr_hit_out        <= (sfr_rd_in | sfr_wr_in | sfr_bit_wr_in)
                            & local_hit;
      ext_std_sel_out    <= (sfr_rd_in | sfr_wr_in | sfr_bit_wr_in)
                            & !local_hit & !mapped_hit;
      pwr_second_sel_out <= (sfr_rd_in | sfr_wr_in | sfr_bit_wr_in)
                            & mapped_hit;
      bit_access_ok_out  <= sfr_bit_wr_in & bit_ok;
    end
  end

  // Address routing: working registers, direct space, wide spaces
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_addr_out    <= 8'h00;
      dir_sfr_sel_out <= 1'b0;
      dir_ram_sel_out <= 1'b0;
      code_addr_out   <= {CODE_AW{1'b0}};
      xdata_addr_out  <= {XDATA_AW{1'b0}};
    end else begin
      reg_addr_out <= {3'b000, status_word_reg[`SW_BANK_HI:`SW_BANK_LO],
                       reg_num_in};
      // Direct upper addresses reach the special area; indirect ones
      // reach the upper half of the 256 byte RAM
      dir_sfr_sel_out <= !dir_indirect_in &&
                         (dir_addr_in >= `SFR_AREA_BASE);
      dir_ram_sel_out <= dir_indirect_in ||
                         (dir_addr_in < `SFR_AREA_BASE);
      code_addr_out   <= code_addr_in;
      xdata_addr_out  <= xdata_addr_in;
    end
  end

  // Flag outputs and decimal adjust helper
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      carry_flag_out        <= 1'b0;
      aux_carry_flag_out    <= 1'b0;
      overflow_flag_out     <= 1'b0;
      parity_flag_out       <= 1'b0;
      bank_sel_out          <= 2'b00;
      da_low_fix_out        <= 1'b0;
      map_select_out        <= 1'b0;
      addr_latch_out_en_out <= 1'b1;
      sys_rst_out           <= 1'b1;
    end else begin
      carry_flag_out        <= status_word_next[`SW_CARRY];
      aux_carry_flag_out    <= status_word_next[`SW_AUX];
      overflow_flag_out     <= status_word_next[`SW_OVFL];
      parity_flag_out       <= status_word_next[`SW_PARITY];
      bank_sel_out          <= status_word_next[`SW_BANK_HI:`SW_BANK_LO];
      // Low nibble needs +6 when aux carry set or nibble above nine
      da_low_fix_out        <= status_word_reg[`SW_AUX] |
                               (acc_in[3:0] > 4'h9);
      map_select_out        <= map_sel_next;
      addr_latch_out_en_out <= ale_en_next;
      sys_rst_out           <= rst_sync_reg;
    end
  end

  // USB clock derivation
  usb_clk_ctl #(
    .DIV (`USB_LS_DIVIDE)
  ) u_usb_clk (
    .ref_clk_in  (ref_clk_in),
    .nrst_in     (nrst_in),
    .srst_in     (rst_sync_reg),
    .pll_en_in   (usb_ctl_reg[`UDC_PLL_EN]),
    .speed_in    (usb_ctl_reg[`UDC_SPEED]),
    .clk_en_in   (usb_ctl_reg[`UDC_CLK_EN]),
    .pll_lock_in (pll_lock_in),
    .ls_clk_out  (usb_ls_clk_out),
    .pll_run_out (pll_run_out),
    .fs_sel_out  (usb_fs_sel_out),
    .ls_sel_out  (usb_ls_sel_out)
  );

endmodule // cpu_status_sfr_map_ctl
`default_nettype wire

// file: cpu_status_sfr_map_ctl_consts.vh
// Purpose: Shared constants for the status word and register-map control
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef CPU_STATUS_SFR_MAP_CTL_CONSTS_VH
`define CPU_STATUS_SFR_MAP_CTL_CONSTS_VH

// Special register addresses
`define ADDR_STATUS_WORD      8'hd0
`define ADDR_SYSTEM_CONTROL   8'hb1
`define ADDR_USB_DEV_CONTROL  8'hc1
`define ADDR_POWER_CTL_SECOND 8'h88

// Status word bit positions
`define SW_CARRY   7
`define SW_AUX     6
`define SW_USER_A  5
`define SW_BANK_HI 4
`define SW_BANK_LO 3
`define SW_OVFL    2
`define SW_USER_B  1
`define SW_PARITY  0

// System control bit positions
`define SC_ALE_EN  5
`define SC_MAP_SEL 4

// USB device control bit positions
`define UDC_PLL_EN  0
`define UDC_SPEED   1
`define UDC_CLK_EN  2

// Reset values
`define RST_STATUS_WORD  8'h00
`define RST_SYS_CONTROL  8'h20
`define RST_USB_DEV_CTL  8'h00

// Clock derivation figures
`define USB_LS_DIVIDE    2
`define USB_PLL_FACTOR   4

// Upper direct addresses reach the special register area
`define SFR_AREA_BASE    8'h80

`endif

// file: cpu_status_sfr_map_ctl_properties.sv
// Purpose: Port-level properties of the status word and map control
// Assumes: Bound to the top module; a single clock domain
// Notes:   Bank, bit access, map, divider and parity checks pause around reset pin activity, which clears registers
`default_nettype none
module cpu_status_sfr_map_ctl_checker (
  // Clock and resets
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic       rst_pin_in,
  // Register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_bit_wr_in,
  input wire logic       bit_access_ok_out,
  input wire logic       pwr_second_sel_out,
  input wire logic       map_select_out,
  // Datapath side
  input wire logic       instr_done_in,
  input wire logic [7:0] acc_in,
  input wire logic [2:0] reg_num_in,
  input wire logic [7:0] reg_addr_out,
  input wire logic [1:0] bank_sel_out,
  input wire logic       parity_flag_out,
  input wire logic       sys_rst_out,
  // USB clock steering
  input wire logic       pll_run_out,
  input wire logic       usb_fs_sel_out,
  input wire logic       usb_ls_sel_out,
  input wire logic       usb_ls_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_d1, pin_d2, rst_d;
  wire  calm;

  // Pin history, because the internal reset rises an edge before sys_rst_out shows
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) {pin_d1, pin_d2, rst_d} <= 3'b001;
    else {pin_d1, pin_d2, rst_d} <= {rst_pin_in, pin_d1, sys_rst_out};
  end
  assign calm = !sys_rst_out && !rst_d && !pin_d1 && !pin_d2;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_bank_addr_form: assert property (
    calm && $past(calm) && $stable(bank_sel_out) |->
    reg_addr_out == {3'b000, bank_sel_out, $past(reg_num_in)})
    else $error("working register address wrong");
  a_bit_ok_addr: assert property (
    calm |-> bit_access_ok_out == ($past(sfr_bit_wr_in) &&
    ($past(sfr_addr_in) & 8'h07) == 8'h00))
    else $error("bit access accept wrong");
  a_pwr_map_only: assert property (
    pwr_second_sel_out |-> $past(map_select_out) &&
    $past(sfr_addr_in) == 8'h88)
    else $error("mapped register select without map bit");
  a_map_sel_hold: assert property (
    calm && $past(calm) && !$past(sfr_wr_in) && !$past(sfr_bit_wr_in)
    |-> $stable(map_select_out))
    else $error("map bit changed without a write");
  a_fs_needs_pll: assert property (
    usb_fs_sel_out |-> pll_run_out && !usb_ls_sel_out)
    else $error("full speed selected without running PLL");
  a_ls_clk_toggle: assert property (
    calm && usb_ls_sel_out && $past(usb_ls_sel_out) |->
    usb_ls_clk_out != $past(usb_ls_clk_out))
    else $error("low speed clock not halving");
  a_ls_clk_gated: assert property (
    !usb_ls_sel_out |-> !usb_ls_clk_out)
    else $error("low speed clock runs while gated");
  a_parity_track: assert property (
    calm && $past(instr_done_in) |-> parity_flag_out == ^$past(acc_in))
    else $error("parity flag wrong");
  a_rst_pin_reach: assert property (
    rst_pin_in [*4] |=> sys_rst_out)
    else $error("reset pin did not reach internal reset");
endmodule // cpu_status_sfr_map_ctl_checker

bind cpu_status_sfr_map_ctl cpu_status_sfr_map_ctl_checker u_chk (.*);
`default_nettype wire

// file: cpu_status_sfr_map_ctl_test.sv
// Purpose: Self-checking bench for the status word and map control
// Assumes: Inputs change by NBA at rising edges; notes checked at falling
// Notes:   Address routing inputs get random values and are checked too
`default_nettype none
module cpu_status_sfr_map_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0, nrst_in, rst_pin_in, sfr_wr_in, sfr_rd_in;
  logic sfr_bit_wr_in, sfr_bit_val_in, instr_done_in, carry_we_in, carry_in;
  logic aux_carry_we_in, aux_carry_in, overflow_we_in, overflow_in;
  logic dir_indirect_in, pll_lock_in, sfr_hit_out, ext_std_sel_out;
  logic [7:0] sfr_addr_in, sfr_wdata_in, acc_in, dir_addr_in, par;
  logic [2:0] sfr_bit_sel_in, reg_num_in;
  logic [15:0] code_addr_in, xdata_addr_in, code_addr_out, xdata_addr_out;
  logic [7:0] sfr_rdata_out, reg_addr_out;
  logic [1:0] bank_sel_out;
  logic pwr_second_sel_out, bit_access_ok_out, dir_sfr_sel_out;
  logic dir_ram_sel_out, carry_flag_out, aux_carry_flag_out;
  logic overflow_flag_out, parity_flag_out, da_low_fix_out, map_select_out;
  logic addr_latch_out_en_out, sys_rst_out, usb_ls_clk_out, pll_run_out;
  logic usb_fs_sel_out, usb_ls_sel_out;
  typedef struct {int due; int sel; logic [7:0] exp;} note_t;
  note_t notes[$];
  int cyc = 0, fail_count = 0, comparisons = 0, ticks = 0;

  cpu_status_sfr_map_ctl DUT (.*);

  always #50 ref_clk_in = ~ref_clk_in;

  // Output groups that a note can refer to
  function automatic logic [7:0] seen(int s);
    case (s)
      0: return sfr_rdata_out;
      1: return {5'h0, sfr_hit_out, ext_std_sel_out, pwr_second_sel_out};
      2: return {6'h0, bank_sel_out};
      3: return reg_addr_out;
      4: return {4'h0, carry_flag_out, aux_carry_flag_out,
                 overflow_flag_out, parity_flag_out};
      5: return {6'h0, map_select_out, addr_latch_out_en_out};
      6: return {5'h0, pll_run_out, usb_fs_sel_out, usb_ls_sel_out};
      7: return {7'h0, sys_rst_out};
      8: return {7'h0, da_low_fix_out};
      9: return {7'h0, bit_access_ok_out};
      10: return {7'h0, usb_ls_clk_out};
      11: return {6'h0, dir_sfr_sel_out, dir_ram_sel_out};
      12: return code_addr_out[7:0];
      13: return code_addr_out[15:8];
      14: return xdata_addr_out[7:0];
      15: return xdata_addr_out[15:8];
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic note(int s, logic [7:0] e, int d);
    notes.push_back('{cyc + d, s, e});
  endtask

  // Watcher: compares each note when its result is due
  always @(negedge ref_clk_in) begin
    cyc++;
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        check($sformatf("group %0d", notes[i].sel),
              seen(notes[i].sel), notes[i].exp);
        notes.delete(i);
      end
    end
  end

  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge ref_clk_in);
    {sfr_addr_in, sfr_wdata_in, sfr_wr_in} <= {ad, d, 1'b1};
    @(posedge ref_clk_in);
    sfr_wr_in <= 1'b0;
  endtask

  // Read with expected data; local hits never route elsewhere
  task automatic rd(logic [7:0] ad, logic [7:0] e, logic h);
    @(posedge ref_clk_in);
    {sfr_addr_in, sfr_rd_in} <= {ad, 1'b1};
    @(posedge ref_clk_in);
    sfr_rd_in <= 1'b0;
    note(0, e, 1);
    note(1, {5'h0, h, ~h, 1'b0}, 1);
  endtask

  task automatic bw(logic [7:0] ad, logic [2:0] b, logic v);
    @(posedge ref_clk_in);
    {sfr_addr_in, sfr_bit_sel_in, sfr_bit_val_in} <= {ad, b, v};
    sfr_bit_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    sfr_bit_wr_in <= 1'b0;
  endtask

  // Bounded wait for the synchronised reset to fall
  task automatic wait_rst;
    repeat (20) begin
      @(posedge ref_clk_in);
      if (sys_rst_out === 1'b0) break;
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge ref_clk_in) begin
    ticks++;
    if (ticks == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    {nrst_in, rst_pin_in, sfr_wr_in, sfr_rd_in, sfr_bit_wr_in} = '0;
    {sfr_bit_val_in, instr_done_in, carry_we_in, carry_in} = '0;
    {aux_carry_we_in, aux_carry_in, overflow_we_in, overflow_in} = '0;
    {dir_indirect_in, pll_lock_in, sfr_addr_in, sfr_wdata_in} = '0;
    {acc_in, dir_addr_in, sfr_bit_sel_in, reg_num_in} = '0;
    {code_addr_in, xdata_addr_in} = '0;
    void'($urandom(32'h42d4c144));
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    wait_rst();
    rd(8'hb1, 8'h20, 1'b1);
    rd(8'hd0, 8'h00, 1'b1);
    rd(8'hc1, 8'h00, 1'b1);
    rd(8'h95, 8'h00, 1'b0);
    // Every bank, random register number
    for (int i = 0; i < 4; i++) begin
      reg_num_in <= 3'($urandom_range(7));
      wr(8'hd0, 8'(i << 3));
      note(2, 8'(i), 1);
      note(3, 8'(i * 8) | 8'(reg_num_in), 2);
      // Keep the register number until its check has been sampled
      @(posedge ref_clk_in);
    end
    // Parity and decimal adjust follow the accumulator
    repeat (6) begin
      @(posedge ref_clk_in);
      {acc_in, instr_done_in} <= {8'($urandom), 1'b1};
      @(posedge ref_clk_in);
      instr_done_in <= 1'b0;
      par = {7'h0, ^acc_in};
      note(4, par, 1);
      note(8, {7'h0, acc_in[3:0] > 4'h9}, 1);
    end
    @(posedge ref_clk_in);
    {carry_we_in, carry_in, aux_carry_we_in, aux_carry_in} <= 4'hf;
    {overflow_we_in, overflow_in} <= 2'b11;
    @(posedge ref_clk_in);
    {carry_we_in, aux_carry_we_in, overflow_we_in} <= 3'b000;
    note(4, 8'h0e | par, 1);
    note(8, 8'h01, 2);
    bw(8'hd0, 3'd7, 1'b0);
    note(9, 8'h01, 1);
    note(4, 8'h06 | par, 1);
    bw(8'hb1, 3'd4, 1'b1);
    note(9, 8'h00, 1);
    note(5, 8'h01, 1);
    // Map switch stays until software changes it
    wr(8'hb1, 8'h10);
    note(5, 8'h02, 1);
    wr(8'h88, 8'h5a);
    note(1, 8'h01, 1);
    repeat (20) @(posedge ref_clk_in);
    note(5, 8'h02, 1);
    rd(8'hd0, 8'h5c | par, 1'b1);
    wr(8'hb1, 8'h20);
    wr(8'h88, 8'h00);
    note(1, 8'h02, 1);
    // All enable, speed and PLL combinations
    for (int c = 0; c < 8; c++) begin
      pll_lock_in <= (c == 7) ? 1'b1 : 1'($urandom);
      wr(8'hc1, 8'(c));
      repeat (3) @(posedge ref_clk_in);
      note(6, {5'h0, c[0], c[2] & c[1] & c[0] & pll_lock_in,
               c[2] & ~c[1]}, 1);
      if (!(c[2] && !c[1])) note(10, 8'h00, 1);
      rd(8'hc1, 8'(c), 1'b1);
    end
    // Direct, code and external data addresses pass registered
    repeat (4) begin
      @(posedge ref_clk_in);
      {dir_addr_in, dir_indirect_in} <= {8'($urandom), 1'($urandom)};
      {code_addr_in, xdata_addr_in} <= $urandom;
      @(posedge ref_clk_in);
      note(11, {6'h0, !dir_indirect_in && dir_addr_in >= 8'h80,
                dir_indirect_in || dir_addr_in < 8'h80}, 1);
      note(12, code_addr_in[7:0], 1);
      note(13, code_addr_in[15:8], 1);
      note(14, xdata_addr_in[7:0], 1);
      note(15, xdata_addr_in[15:8], 1);
    end
    // Reset pin clears the status word and the map bit
    wr(8'hb1, 8'h10);
    @(posedge ref_clk_in);
    rst_pin_in <= 1'b1;
    note(7, 8'h01, 5);
    // Pin held two machine cycles of six clocks each
    repeat (12) @(posedge ref_clk_in);
    rst_pin_in <= 1'b0;
    wait_rst();
    note(4, 8'h00, 1);
    note(2, 8'h00, 1);
    note(5, 8'h01, 1);
    repeat (8) @(posedge ref_clk_in);
    finish_test();
  end
endmodule // cpu_status_sfr_map_ctl_test
`default_nettype wire

// file: usb_clk_ctl.v
// Purpose: USB clock derivation control: divider and PLL steering
// Assumes: Synchronous reset already synchronised by the caller
// Notes:   The PLL itself and the glitch-free clock mux are analog/
//          library cells outside; this block steers them from flops
`include "cpu_status_sfr_map_ctl_consts.vh"
`default_nettype none

module usb_clk_ctl #(
  parameter integer DIV = `USB_LS_DIVIDE
) (
  // Clock and resets
  input  wire ref_clk_in,
  input  wire nrst_in,
  input  wire srst_in,
  // Control bits
  input  wire pll_en_in,
  input  wire speed_in,
  input  wire clk_en_in,
  input  wire pll_lock_in,
  // Clock steering
  output reg  ls_clk_out,
  output reg  pll_run_out,
  output reg  fs_sel_out,
  output reg  ls_sel_out
);

  localparam integer CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam integer HALF_I = DIV / 2 - 1;
  localparam [CW-1:0] HALF = HALF_I[CW-1:0];

  reg [CW-1:0] div_cnt_reg;

  // Divided clock toggles every DIV/2 cycles; held low when not chosen
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_reg <= {CW{1'b0}};
      ls_clk_out  <= 1'b0;
    end else if (srst_in || !clk_en_in || speed_in) begin
      div_cnt_reg <= {CW{1'b0}};
      ls_clk_out  <= 1'b0;
    end else if (div_cnt_reg == HALF) begin
      div_cnt_reg <= {CW{1'b0}};
      ls_clk_out  <= ~ls_clk_out;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // PLL runs only with its enable; full speed waits for lock so that
  // the module never sees a wandering clock
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_run_out <= 1'b0;
      fs_sel_out  <= 1'b0;
      ls_sel_out  <= 1'b0;
    end else if (srst_in) begin
      pll_run_out <= 1'b0;
      fs_sel_out  <= 1'b0;
      ls_sel_out  <= 1'b0;
    end else begin
      pll_run_out <= pll_en_in;
      fs_sel_out  <= clk_en_in & speed_in & pll_en_in
                     & pll_lock_in;
      ls_sel_out  <= clk_en_in & ~speed_in;
    end
  end

endmodule // usb_clk_ctl
`default_nettype wire
